// ---- drive_status_defines.svh ----
// offsets, field positions and reset values for the drive status selector
`ifndef DRIVE_STATUS_DEFINES_SVH
`define DRIVE_STATUS_DEFINES_SVH

`define OFS_OUT_SEL       12'h000
`define OFS_SPEED_BAND    12'h004
`define OFS_SET_SPEED     12'h008
`define OFS_STANDSTILL    12'h00C
`define OFS_OVERLOAD      12'h010
`define OFS_UNDERLOAD     12'h014
`define OFS_COND_STATUS   12'h018
`define OFS_OUT_STATUS    12'h01C
`define OFS_MODE          12'h020

`define SEL_FIELD_W       4
`define THERMAL_FULL      16'h0064
`define RST_SEL           32'h0000_0000
`define RST_SETPOINT      16'h0000

`endif

// ---- drive_status_pkg.sv ----
// types shared by the drive status selector
package drive_status_pkg;

	typedef enum logic [3:0] {
		COND_READY,
		COND_ON,
		COND_RUN,
		COND_STOPPED,
		COND_JOG,
		COND_ACCEL,
		COND_CONST,
		COND_DECEL,
		COND_ZERO_SPEED,
		COND_AT_SPEED,
		COND_AT_SET_SPEED,
		COND_CUR_OVER,
		COND_CUR_UNDER,
		COND_THERMAL,
		COND_NONE_E,
		COND_NONE_F
	} cond_sel_t;

	typedef enum logic {
		CTRL_VHZ,
		CTRL_OPEN_VECTOR
	} ctrl_mode_t;

endpackage

// ---- drive_status_output_selector.sv ----
// drive status conditions and per-output condition selection
`timescale 1ns/1ps
`include "drive_status_defines.svh"

// What this block does
// - four outputs, two opto, two relay
// - each output follows its own selected condition
// - ready after soft start, enabled, no fault
// - volts-per-hertz on: ready and pwm active
// - open-vector on: ready and flux present
// - run: on and direction command present
// - stopped: stop command and motor stopping
// - jog true throughout jog mode
// - accelerating while ramping upward
// - constant speed when not ramping
// - decelerating while ramping downward and not upward
// - zero speed: speed below standstill threshold
// - at speed: speed within tolerance band
// - at set speed: speed at or above threshold
// - overload: current above overload setpoint
// - underload: current below underload setpoint
// - thermal: remaining capacity below 100 percent
// - band test: abs(ref minus demand) below band
module drive_status_output_selector #(
	parameter int SPEED_W = 16,
	parameter int CUR_W   = 16
) (
	input  wire logic               sys_clk_i,
	input  wire logic               rstn_i,
	input  wire logic               psel_i,
	input  wire logic               penable_i,
	input  wire logic               pwrite_i,
	input  wire logic [11:0]        paddr_i,
	input  wire logic [31:0]        pwdata_i,
	output logic      [31:0]        prdata_o,
	output logic                    pready_o,
	output logic                    pslverr_o,
	input  wire logic               soft_start_done_i,
	input  wire logic               drive_enable_i,
	input  wire logic               fault_i,
	input  wire logic               pwm_active_i,
	input  wire logic               flux_present_i,
	input  wire logic               direction_command_i,
	input  wire logic               stop_command_i,
	input  wire logic               motor_stopping_i,
	input  wire logic               jog_mode_i,
	input  wire logic               ramp_up_i,
	input  wire logic               ramp_down_i,
	input  wire logic [SPEED_W-1:0] motor_speed_i,
	input  wire logic [SPEED_W-1:0] speed_ref_i,
	input  wire logic [SPEED_W-1:0] speed_demand_i,
	input  wire logic [CUR_W-1:0]   motor_current_i,
	input  wire logic [15:0]        overload_left_i,
	output logic      [1:0]         opto_out_o,
	output logic      [1:0]         relay_out_o
);
	import drive_status_pkg::*;

	logic [31:0]        out_sel_q;
	logic [SPEED_W-1:0] speed_band_setting_q;
	logic [SPEED_W-1:0] set_speed_threshold_q;
	logic [SPEED_W-1:0] standstill_threshold_q;
	logic [CUR_W-1:0]   overload_sp_q;
	logic [CUR_W-1:0]   underload_sp_q;
	ctrl_mode_t         mode_q;
	logic [15:0]        cond_q;
	logic [3:0]         out_q;
	logic [15:0]        cond_d;
	logic [3:0]         out_d;
	logic [31:0]        rdata_d;
	logic [31:0]        prdata_q;

	function automatic logic [SPEED_W-1:0] abs_diff(
		input logic [SPEED_W-1:0] a,
		input logic [SPEED_W-1:0] b
	);
		abs_diff = (a >= b) ? (a - b) : (b - a);
	endfunction

	function automatic logic pick(
		input logic [15:0] conds,
		input logic [3:0]  sel
	);
		pick = conds[sel];
	endfunction

	// bus decode
	wire access_w = psel_i & penable_i;
	wire wr_w     = access_w & pwrite_i;
	wire hit_sel  = paddr_i == `OFS_OUT_SEL;
	wire hit_band = paddr_i == `OFS_SPEED_BAND;
	wire hit_set  = paddr_i == `OFS_SET_SPEED;
	wire hit_std  = paddr_i == `OFS_STANDSTILL;
	wire hit_ovl  = paddr_i == `OFS_OVERLOAD;
	wire hit_unl  = paddr_i == `OFS_UNDERLOAD;
	wire hit_cst  = paddr_i == `OFS_COND_STATUS;
	wire hit_ost  = paddr_i == `OFS_OUT_STATUS;
	wire hit_mode = paddr_i == `OFS_MODE;
	wire mapped_w = hit_sel | hit_band | hit_set | hit_std | hit_ovl
		| hit_unl | hit_cst | hit_ost | hit_mode;

	assign pready_o  = 1'b1;
	assign pslverr_o = access_w & ~mapped_w;
	assign prdata_o  = prdata_q;

	always_comb begin
		rdata_d = 32'h0000_0000;
		if (hit_sel)  rdata_d = out_sel_q;
		if (hit_band) rdata_d = 32'(speed_band_setting_q);
		if (hit_set)  rdata_d = 32'(set_speed_threshold_q);
		if (hit_std)  rdata_d = 32'(standstill_threshold_q);
		if (hit_ovl)  rdata_d = 32'(overload_sp_q);
		if (hit_unl)  rdata_d = 32'(underload_sp_q);
		if (hit_cst)  rdata_d = {16'h0000, cond_q};
		if (hit_ost)  rdata_d = {28'h000_0000, out_q};
		if (hit_mode) rdata_d = {31'h0000_0000, mode_q == CTRL_OPEN_VECTOR};
	end

	// read data registered at the end of the setup cycle; valid in the access cycle
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel_i & ~penable_i & ~pwrite_i) begin
			prdata_q <= rdata_d;
		end
	end

	// setting registers
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			out_sel_q              <= `RST_SEL;
			speed_band_setting_q   <= SPEED_W'(`RST_SETPOINT);
			set_speed_threshold_q  <= SPEED_W'(`RST_SETPOINT);
			standstill_threshold_q <= SPEED_W'(`RST_SETPOINT);
			overload_sp_q          <= CUR_W'(`RST_SETPOINT);
			underload_sp_q         <= CUR_W'(`RST_SETPOINT);
			mode_q                 <= CTRL_VHZ;
		end else if (wr_w) begin
			if (hit_sel)  out_sel_q              <= pwdata_i;
			if (hit_band) speed_band_setting_q   <= pwdata_i[SPEED_W-1:0];
			if (hit_set)  set_speed_threshold_q  <= pwdata_i[SPEED_W-1:0];
			if (hit_std)  standstill_threshold_q <= pwdata_i[SPEED_W-1:0];
			if (hit_ovl)  overload_sp_q          <= pwdata_i[CUR_W-1:0];
			if (hit_unl)  underload_sp_q         <= pwdata_i[CUR_W-1:0];
			if (hit_mode) mode_q <= pwdata_i[0] ? CTRL_OPEN_VECTOR : CTRL_VHZ;
		end
	end

	// condition derivation
	wire ready_w = soft_start_done_i & drive_enable_i & ~fault_i;
	wire on_vhz_w = ready_w & pwm_active_i;
	wire on_ov_w  = ready_w & flux_present_i;
	wire on_w  = (mode_q == CTRL_OPEN_VECTOR) ? on_ov_w : on_vhz_w;
	wire run_w = on_w & direction_command_i;
	wire stopped_w = stop_command_i & motor_stopping_i;
	// up wins if both asserted, keeping exactly one true
	wire accel_w = ramp_up_i;
	wire decel_w = ramp_down_i & ~ramp_up_i;
	wire const_w = ~accel_w & ~decel_w;
	wire zero_w = motor_speed_i < standstill_threshold_q;
	wire [SPEED_W-1:0] band_err_w = abs_diff(speed_ref_i, speed_demand_i);
	wire at_speed_w = band_err_w < speed_band_setting_q;
	wire at_set_w = motor_speed_i >= set_speed_threshold_q;
	wire over_w  = motor_current_i > overload_sp_q;
	wire under_w = motor_current_i < underload_sp_q;
	wire thermal_w = overload_left_i < `THERMAL_FULL;

	always_comb begin
		cond_d = 16'h0000;
		cond_d[COND_READY]        = ready_w;
		cond_d[COND_ON]           = on_w;
		cond_d[COND_RUN]          = run_w;
		cond_d[COND_STOPPED]      = stopped_w;
		cond_d[COND_JOG]          = jog_mode_i;
		cond_d[COND_ACCEL]        = accel_w;
		cond_d[COND_CONST]        = const_w;
		cond_d[COND_DECEL]        = decel_w;
		cond_d[COND_ZERO_SPEED]   = zero_w;
		cond_d[COND_AT_SPEED]     = at_speed_w;
		cond_d[COND_AT_SET_SPEED] = at_set_w;
		cond_d[COND_CUR_OVER]     = over_w;
		cond_d[COND_CUR_UNDER]    = under_w;
		cond_d[COND_THERMAL]      = thermal_w;
	end

	// per-output selection from the current conditions
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			out_d[i] = pick(cond_d,
				out_sel_q[i*`SEL_FIELD_W +: `SEL_FIELD_W]);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			cond_q <= 16'h0000;
			out_q  <= 4'h0;
		end else begin
			cond_q <= cond_d;
			out_q  <= out_d;
		end
	end

	assign opto_out_o  = out_q[1:0];
	assign relay_out_o = out_q[3:2];

endmodule

// ---- drive_status_monitor.sv ----
// assertion checker for the drive status selector
`timescale 1ns/1ps
module drive_status_monitor (
	input wire logic        sys_clk_i,
	input wire logic        rstn_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        soft_start_done_i,
	input wire logic        drive_enable_i,
	input wire logic        fault_i,
	input wire logic        ramp_up_i,
	input wire logic        ramp_down_i,
	input wire logic [1:0]  opto_out_o,
	input wire logic [1:0]  relay_out_o
);
	localparam logic [15:0] MASK = 16'hC0E1;
	logic [15:0] sel_q;
	logic [3:0]  hit_q;
	logic [3:0]  exp_q;
	wire  [3:0]  outs = {relay_out_o, opto_out_o};
	wire  [15:0] cond = {8'h00, ramp_down_i & !ramp_up_i,
		!(ramp_up_i | ramp_down_i), ramp_up_i, 4'h0,
		soft_start_done_i & drive_enable_i & !fault_i};
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i)
			sel_q <= 16'h0000;
		else if (psel_i && penable_i && pwrite_i && pready_o && paddr_i == 12'h000)
			sel_q <= pwdata_i[15:0];
		for (int k = 0; k < 4; k++) begin
			hit_q[k] <= rstn_i && MASK[sel_q[4*k+:4]];
			exp_q[k] <= cond[sel_q[4*k+:4]];
		end
	end
	chk_opto_zero: assert property (hit_q[0] |-> outs[0] == exp_q[0])
		else $error("opto output 0 wrong");
	chk_opto_one: assert property (hit_q[1] |-> outs[1] == exp_q[1])
		else $error("opto output 1 wrong");
	chk_relay_zero: assert property (hit_q[2] |-> outs[2] == exp_q[2])
		else $error("relay output 0 wrong");
	chk_relay_one: assert property (hit_q[3] |-> outs[3] == exp_q[3])
		else $error("relay output 1 wrong");
	chk_reset_idle: assert property (!$past(rstn_i) |-> outs == 4'h0)
		else $error("outputs active after reset");
	chk_bad_addr: assert property (psel_i && penable_i && paddr_i > 12'h020
		|-> pslverr_o)
		else $error("unmapped access not flagged");
	chk_good_addr: assert property (psel_i && penable_i && paddr_i <= 12'h020
		&& paddr_i[1:0] == 2'b00 |-> !pslverr_o)
		else $error("mapped access flagged");
	chk_bus_idle: assert property (pready_o && (penable_i || !pslverr_o))
		else $error("bus response wrong");
endmodule

// ---- drive_output_load.sv ----
// load model: two opto isolators and two relay coils
`timescale 1ns/1ps
module drive_output_load (
	input  wire logic [1:0] opto_i,
	input  wire logic [1:0] relay_i,
	output logic      [3:0] load_on_o
);
	assign load_on_o = {relay_i, opto_i};
endmodule

// ---- drive_status_output_selector_tb_top.sv ----
// self-checking bench for the drive status selector
`timescale 1ns/1ps
module drive_status_output_selector_tb_top;
	localparam logic [10:0] FL [4] = '{11'h6FF, 11'h7FD, 11'h690, 11'h66A};
	localparam logic [15:0] SP [4] = '{16'h0064, 16'h0063, 16'h0000, 16'h0065};
	localparam logic [15:0] RF [4] = '{16'h000A, 16'h0000, 16'h0005, 16'h0000};
	localparam logic [15:0] DM [4] = '{16'h0000, 16'h0009, 16'h0009, 16'h0000};
	localparam logic [15:0] CU [4] = '{16'h0064, 16'h0065, 16'h0063, 16'h0000};
	localparam logic [15:0] OV [4] = '{16'h0064, 16'h0063, 16'h0000, 16'hFFFF};
	logic        sys_clk_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, e;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, r;
	logic        pslverr_o;
	logic [1:0]  opto_out_o, relay_out_o;
	logic [3:0]  load_on;
	logic [10:0] fl;
	logic [15:0] motor_speed_i, speed_ref_i, speed_demand_i;
	logic [15:0] motor_current_i, overload_left_i, m;
	wire         soft_start_done_i, drive_enable_i, fault_i, pwm_active_i;
	wire         flux_present_i, direction_command_i, stop_command_i;
	wire         motor_stopping_i, jog_mode_i, ramp_up_i, ramp_down_i;
	int          n_fail, checks_done;
	assign {soft_start_done_i, drive_enable_i, fault_i, pwm_active_i,
		flux_present_i, direction_command_i, stop_command_i, motor_stopping_i,
		jog_mode_i, ramp_up_i, ramp_down_i} = fl;
	drive_status_output_selector u_dut (.*);
	drive_output_load u_load (.opto_i(opto_out_o), .relay_i(relay_out_o),
		.load_on_o(load_on));
	function automatic logic [15:0] model(input logic md);
		logic        rd, on;
		logic [15:0] ad;
		rd = soft_start_done_i & drive_enable_i & !fault_i;
		on = rd & (md ? flux_present_i : pwm_active_i);
		ad = speed_ref_i > speed_demand_i ? speed_ref_i - speed_demand_i
			: speed_demand_i - speed_ref_i;
		return {2'b00, overload_left_i < 16'h0064, motor_current_i < 16'h0064,
			motor_current_i > 16'h0064, motor_speed_i >= 16'h0064,
			ad < 16'h000A, motor_speed_i < 16'h0064, ramp_down_i & !ramp_up_i,
			!(ramp_up_i | ramp_down_i), ramp_up_i, jog_mode_i,
			stop_command_i & motor_stopping_i, on & direction_command_i, on, rd};
	endfunction
	task automatic summarize();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		checks_done++;
		if (g !== x) begin
			n_fail++;
			$display("Error %0t got %h expected %h", $time, g, x);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int i;
		@(posedge sys_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge sys_clk_i);
			if (pready_o === 1'b1) break;
		end
		if (i == 16) begin
			n_fail++;
			summarize();
		end
		r = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	initial begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		{rstn_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, fl} = '0;
		{motor_speed_i, speed_ref_i, speed_demand_i} = '0;
		{motor_current_i, overload_left_i} = '0;
		repeat (8) @(posedge sys_clk_i);
		chk({28'h000_0000, load_on}, 32'h0000_0000);
		rstn_i <= 1'b1;
		for (int a = 0; a <= 36; a += 4) begin
			xfer(1'b0, 12'(a), 32'h0000_0000);
			if (a < 24 || a > 28) chk(r, 32'h0000_0000);
			chk({31'h0000_0000, e}, {31'h0000_0000, a == 36});
		end
		$display("reset test done");
		for (int a = 4; a <= 20; a += 4)
			xfer(1'b1, 12'(a), a == 4 ? 32'h0000_000A : 32'h0000_0064);
		for (int md = 0; md < 2; md++) begin
			xfer(1'b1, 12'h020, 32'(md));
			for (int p = 0; p < 4; p++) begin
				fl <= FL[p];
				{motor_speed_i, speed_ref_i, speed_demand_i} <= {SP[p], RF[p], DM[p]};
				{motor_current_i, overload_left_i} <= {CU[p], OV[p]};
				xfer(1'b0, 12'h018, 32'h0000_0000);
				m = model(md[0]);
				chk(r, {18'h0_0000, m[13:0]});
				for (int k = 0; k < 16; k += 4) begin
					xfer(1'b1, 12'h000, {16'h0000, 4'(k+3), 4'(k+2), 4'(k+1), 4'(k)});
					repeat (2) @(posedge sys_clk_i);
					chk({28'h000_0000, load_on}, {28'h000_0000, m[k+:4]});
					xfer(1'b0, 12'h01C, 32'h0000_0000);
					chk(r, {28'h000_0000, m[k+:4]});
				end
			end
			$display("condition test done");
		end
		rstn_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		chk({28'h000_0000, load_on}, 32'h0000_0000);
		rstn_i <= 1'b1;
		xfer(1'b0, 12'h000, 32'h0000_0000);
		chk(r, 32'h0000_0000);
		$display("second reset test done");
		summarize();
	end
endmodule
bind drive_status_output_selector drive_status_monitor u_mon (.*);
